//--- twes_pkg.sv
package twes_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int TWES_ADDR_W = 14;
    localparam int TWES_PAGE_W = 6;
    localparam int TWES_HI_W = 6;
    localparam int TWES_PAGE_BYTES = 64;
    localparam int TWES_MEM_BYTES = 16384;

    // ------------------------------------------------------------
    // Slave address layout
    // ------------------------------------------------------------
    // Device-type code is arbitrary, not any real family code
    localparam logic [3:0] TWES_DEV_TYPE = 4'h5;
    localparam int TWES_TYPE_LSB = 4;
    localparam int TWES_SEL_LSB = 1;
    localparam int TWES_RW_BIT = 0;

    // ------------------------------------------------------------
    // Bit counter values
    // ------------------------------------------------------------
    localparam logic [3:0] TWES_CNT_ZERO = 4'h0;
    localparam logic [3:0] TWES_CNT_ACK = 4'h8;
    localparam logic [3:0] TWES_CNT_END = 4'h9;

    // ------------------------------------------------------------
    // Program cycle timing
    // ------------------------------------------------------------
    localparam int TWES_CLK_FREQ_HZ = 100_000_000;
    localparam int TWES_PROG_TIME_MS = 6;
    // Longest time, rounds down
    localparam int TWES_PROG_CYC = TWES_PROG_TIME_MS * (TWES_CLK_FREQ_HZ / 1000);
    localparam int TWES_TMR_W = 20;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TWES_IDLE = 3'b000,
        TWES_DEV = 3'b001,
        TWES_AHI = 3'b010,
        TWES_ALO = 3'b011,
        TWES_WDAT = 3'b100,
        TWES_RDAT = 3'b101
    } twes_fsm_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
        logic [2:0] sel;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } twes_lines_t;

    typedef struct packed {
        twes_fsm_t fsm;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic [TWES_ADDR_W-1:0] addr;
        logic [TWES_HI_W-1:0] hi;
        logic nack;
        logic pending;
        logic busy;
        logic drive_n;
        logic sda_lvl;
        logic standby;
        logic [TWES_TMR_W-1:0] tmr;
        logic [TWES_PAGE_W:0] cidx;
        logic [TWES_PAGE_BYTES-1:0] valid;
    } twes_state_t;

endpackage : twes_pkg

//--- twes_line_sync.sv
`timescale 1ns/10ps
module twes_line_sync
    import twes_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic scl_in, // Serial clock pin
    input wire logic sda_in, // Serial data pin level
    input wire logic [2:0] sel_in, // Chip-select straps
    input wire logic wp_in, // Write-protect pin
    output twes_pkg::twes_lines_t ev // Sampled levels and events
);
    import twes_pkg::*;

    typedef struct packed {
        logic [5:0] meta;
        logic [5:0] sync;
        logic scl_p;
        logic sda_p;
    } twes_sync_t;

    twes_sync_t st;
    twes_sync_t next_st;

    // ------------------------------------------------------------
    // Two-stage synchroniser, then one more stage for edges
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.meta = {wp_in, sel_in, scl_in, sda_in};
        next_st.sync = st.meta;
        next_st.scl_p = st.sync[1];
        next_st.sda_p = st.sync[0];
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '{meta: 6'h03, sync: 6'h03, scl_p: 1'b1, sda_p: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        ev.scl = st.sync[1];
        ev.sda = st.sync[0];
        ev.wp = st.sync[5];
        ev.sel = st.sync[4:2];
        ev.scl_rise = st.sync[1] && !st.scl_p;
        ev.scl_fall = !st.sync[1] && st.scl_p;
        ev.start = st.sync[1] && st.scl_p && st.sda_p && !st.sync[0];
        ev.stop = st.sync[1] && st.scl_p && !st.sda_p && st.sync[0];
    end

endmodule : twes_line_sync

//--- twes_eeprom_slave.sv
// Summary of operation
// - Select only when all three slave-address select bits equal the straps.
// - Data line changes only while clock is low, except start and stop.
// - Start is data falling with clock high; ignore traffic before one.
// - Stop is data rising with clock high; it ends the transaction.
// - After stop go to standby unless a program cycle was started.
// - Two location bytes follow; low 6 bits of first, all 8 of second.
// - Byte write acks location and data bytes; program starts at stop.
// - While programming, bus inputs are ignored and nothing is answered.
// - Page writes stay in one aligned 64-byte page, wrapping within it.
// - A page write may start anywhere inside its page.
// - Up to 63 more bytes; ack each, then advance the address.
// - Beyond 64 bytes, wrapped address overwrites earlier buffered bytes.
// - Address polling gets no ack while busy, ack once finished.
// - With write-protect high, ack addresses, nack first data, no program.
// - Direction bit one means read; otherwise address handled as write.
// - Address counter holds last accessed location plus one.
// - Read address is acked, then bytes are shifted out until nack/stop.
// - Master ack asks for the next byte; nack or stop ends the read.
// - Read counter spans all address bits and wraps to zero.
// - Receiver pulls data low on ninth clock; transmitter releases it.
// - Slave address: 4-bit type, 3-bit select, then direction bit last.
// - Program cycle lasts at most 6 ms from the stop.
`timescale 1ns/10ps
module twes_eeprom_slave
    import twes_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = TWES_PROG_CYC
) (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic nrst, // Async reset, active low
    input wire logic scl_in, // Serial clock from master
    input wire logic sda_in, // Serial data line level
    output logic sda_out, // Data pin drive level, always low
    output logic sda_oe_n, // Data pin enable, low pulls down
    input wire logic chip_select_strap_high, // Select strap, top bit
    input wire logic chip_select_strap_mid, // Select strap, middle bit
    input wire logic chip_select_strap_low, // Select strap, bottom bit
    input wire logic wp_in, // Write protect, high blocks writes
    output logic busy, // Program cycle running
    output logic standby // Low-power standby state
);
    import twes_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem [TWES_MEM_BYTES];
    logic [7:0] pbuf [TWES_PAGE_BYTES];

    twes_state_t st;
    twes_state_t next_st;
    twes_lines_t ev;

    logic pbuf_we;
    logic [TWES_PAGE_W-1:0] pbuf_idx;
    logic [7:0] rd_byte;
    logic sel_ok;
    logic commit_we;
    logic [TWES_PAGE_W-1:0] commit_idx;

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    // pins synchronised before use
    twes_line_sync u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sel_in({chip_select_strap_high, chip_select_strap_mid, chip_select_strap_low}),
        .wp_in(wp_in),
        .ev(ev)
    );

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    assign rd_byte = mem[st.addr];
    assign pbuf_idx = st.addr[TWES_PAGE_W-1:0];
    assign commit_idx = st.cidx[TWES_PAGE_W-1:0];
    // all three select bits must match straps
    assign sel_ok = (st.shreg[7:TWES_TYPE_LSB] == TWES_DEV_TYPE)
        && (st.shreg[TWES_TYPE_LSB-1:TWES_SEL_LSB] == ev.sel);
    assign commit_we = st.busy && !st.cidx[TWES_PAGE_W] && st.valid[commit_idx];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        pbuf_we = 1'b0;
        if (st.busy) begin
            // bus ignored during the program cycle
            if (!st.cidx[TWES_PAGE_W]) begin
                next_st.cidx = st.cidx + 1'b1;
            end
            // cycle ends after the fixed count
            if (st.tmr == TWES_TMR_W'(PROG_CYCLES - 1)) begin
                next_st.busy = 1'b0;
                next_st.valid = '0;
                next_st.tmr = '0;
                next_st.standby = 1'b1;
            end else begin
                next_st.tmr = st.tmr + 1'b1;
            end
        end else if (ev.start) begin
            // a start (or repeated start) opens a transaction
            next_st.fsm = TWES_DEV;
            next_st.cnt = TWES_CNT_ZERO;
            // Aborted write must not leak stale bytes into a later commit
            next_st.valid = '0;
            next_st.pending = 1'b0;
            next_st.drive_n = 1'b1;
            next_st.standby = 1'b0;
        end else if (ev.stop) begin
            next_st.fsm = TWES_IDLE;
            next_st.drive_n = 1'b1;
            if (st.pending) begin
                next_st.busy = 1'b1;
                next_st.tmr = '0;
                next_st.cidx = '0;
                next_st.pending = 1'b0;
            end else begin
                next_st.standby = 1'b1;
            end
        end else if (st.fsm != TWES_IDLE) begin
            if (ev.scl_rise) begin
                if (st.cnt < TWES_CNT_ACK) begin
                    next_st.shreg = {st.shreg[6:0], ev.sda};
                end else begin
                    // Ninth clock: catch the master's answer
                    next_st.nack = ev.sda;
                end
                next_st.cnt = st.cnt + 1'b1;
            end else if (ev.scl_fall) begin
                // data pin only changes on the clock's low phase
                if (st.cnt == TWES_CNT_ACK) begin
                    next_st.drive_n = 1'b1;
                    case (st.fsm)
                        TWES_DEV: begin
                            if (sel_ok) begin
                                next_st.drive_n = 1'b0;
                                // direction bit picks read or write
                                next_st.fsm = st.shreg[TWES_RW_BIT] ? TWES_RDAT : TWES_AHI;
                            end else begin
                                next_st.fsm = TWES_IDLE;
                                next_st.standby = 1'b1;
                            end
                        end
                        TWES_AHI: begin
                            // only the low bits of the high byte count
                            next_st.hi = st.shreg[TWES_HI_W-1:0];
                            next_st.drive_n = 1'b0;
                            next_st.fsm = TWES_ALO;
                        end
                        TWES_ALO: begin
                            next_st.addr = {st.hi, st.shreg};
                            next_st.drive_n = 1'b0;
                            next_st.fsm = TWES_WDAT;
                        end
                        TWES_WDAT: begin
                            if (ev.wp) begin
                                next_st.fsm = TWES_IDLE;
                                next_st.pending = 1'b0;
                            end else begin
                                next_st.drive_n = 1'b0;
                                pbuf_we = 1'b1;
                                next_st.valid[pbuf_idx] = 1'b1;
                                next_st.pending = 1'b1;
                                // any start offset in the page
                                next_st.addr = {st.addr[TWES_ADDR_W-1:TWES_PAGE_W],
                                    pbuf_idx + 1'b1};
                            end
                        end
                        default: begin
                            // Read: release for master's ack slot
                            next_st.drive_n = 1'b1;
                        end
                    endcase
                end else if (st.cnt == TWES_CNT_END) begin
                    next_st.cnt = TWES_CNT_ZERO;
                    next_st.drive_n = 1'b1;
                    if (st.fsm == TWES_RDAT) begin
                        if (st.nack) begin
                            next_st.fsm = TWES_IDLE;
                        end else begin
                            // data from counter, counter moves on
                            next_st.tx = rd_byte;
                            next_st.addr = st.addr + 1'b1;
                            next_st.drive_n = rd_byte[7];
                        end
                    end
                end else if (st.fsm == TWES_RDAT) begin
                    // shift the byte out MSB first
                    next_st.drive_n = st.tx[3'(4'd7 - st.cnt)];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '{fsm: TWES_IDLE, cnt: TWES_CNT_ZERO, shreg: 8'h00, tx: 8'h00,
                addr: '0, hi: '0, nack: 1'b1, pending: 1'b0, busy: 1'b0,
                drive_n: 1'b1, sda_lvl: 1'b0, standby: 1'b1, tmr: '0,
                cidx: '0, valid: '0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Page buffer and array
    // ------------------------------------------------------------
    // Array writes one buffered byte per cycle inside the busy window;
    // 64 cycles is far below the program time, so no extra wait.
    always_ff @(posedge clk_sys) begin
        if (pbuf_we) begin
            pbuf[pbuf_idx] <= st.shreg;
        end
        if (commit_we) begin
            mem[{st.addr[TWES_ADDR_W-1:TWES_PAGE_W], commit_idx}] <= pbuf[commit_idx];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // open-drain, only ever drives low
    assign sda_out = st.sda_lvl;
    assign sda_oe_n = st.drive_n;
    assign busy = st.busy;
    assign standby = st.standby;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    logic [TWES_TMR_W:0] busy_len;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy_len <= '0;
        end else begin
            busy_len <= st.busy ? busy_len + 1'b1 : '0;
        end
    end

    a_sel_mismatch_nack: assert property (
        (st.fsm == TWES_DEV && st.cnt == TWES_CNT_ACK && ev.scl_fall && !sel_ok
            && !st.busy && !ev.start && !ev.stop) |=> sda_oe_n && st.fsm == TWES_IDLE)
        else $error("unselected address was acknowledged");

    a_drive_on_low: assert property (
        $changed(sda_oe_n) |-> $past(ev.scl_fall) || $past(ev.start) || $past(ev.stop)
            || $past(st.busy))
        else $error("data pin changed outside clock low phase");

    a_start_opens: assert property (
        (ev.start && !st.busy) |=> st.fsm == TWES_DEV && st.cnt == TWES_CNT_ZERO)
        else $error("start did not open a transaction");

    a_stop_standby: assert property (
        (ev.stop && !st.busy && !st.pending) |=> standby && !busy && st.fsm == TWES_IDLE)
        else $error("stop without write did not reach standby");

    a_stop_programs: assert property (
        (ev.stop && !st.busy && st.pending) |=> busy && !standby)
        else $error("pending write did not start program cycle");

    a_busy_silent: assert property (
        busy |-> sda_oe_n && st.fsm == TWES_IDLE)
        else $error("device drove the bus while programming");

    a_page_wrap: assert property (
        pbuf_we |=> st.addr[TWES_ADDR_W-1:TWES_PAGE_W]
            == $past(st.addr[TWES_ADDR_W-1:TWES_PAGE_W])
            && st.addr[TWES_PAGE_W-1:0] == $past(pbuf_idx) + 1'b1)
        else $error("page write left its page");

    a_wp_refuse: assert property (
        (st.fsm == TWES_WDAT && st.cnt == TWES_CNT_ACK && ev.scl_fall && ev.wp
            && !ev.start && !ev.stop) |=> sda_oe_n && !st.pending)
        else $error("protected write was acknowledged");

    a_read_wrap: assert property (
        (st.fsm == TWES_RDAT && st.cnt == TWES_CNT_END && ev.scl_fall && !st.nack
            && !ev.start && !ev.stop && !st.busy) |=> st.addr == $past(st.addr) + 1'b1)
        else $error("read counter did not advance");

    a_prog_time: assert property (
        busy |-> busy_len < (TWES_TMR_W+1)'(PROG_CYCLES))
        else $error("program cycle too long");

    a_poll_ignored: assert property (
        (busy && ev.start) |=> st.fsm == TWES_IDLE && sda_oe_n)
        else $error("start answered while programming");

    a_addr_ack: assert property (
        (st.fsm == TWES_AHI && st.cnt == TWES_CNT_ACK && ev.scl_fall && !busy) |=> !sda_oe_n)
        else $error("location byte not acknowledged");

    a_ack_release: assert property (
        (st.cnt == TWES_CNT_END && ev.scl_fall && st.fsm != TWES_RDAT
            && st.fsm != TWES_IDLE && !busy) |=> sda_oe_n)
        else $error("acknowledge not released after ninth clock");

    a_read_nack_end: assert property (
        (st.fsm == TWES_RDAT && st.cnt == TWES_CNT_END && ev.scl_fall && st.nack
            && !busy) |=> sda_oe_n && st.fsm == TWES_IDLE)
        else $error("read went on after master nack");

    a_first_bit: assert property (
        (st.fsm == TWES_RDAT && st.cnt == TWES_CNT_END && ev.scl_fall && !st.nack
            && !busy) |=> sda_oe_n == $past(rd_byte[7]))
        else $error("first read bit not driven");

    a_done_standby: assert property (
        $fell(busy) |-> standby && st.fsm == TWES_IDLE)
        else $error("program end did not reach standby");

    c_byte_write: cover property (ev.stop && st.pending ##1 busy);
    c_read_ack: cover property (st.fsm == TWES_RDAT && ev.scl_fall && st.cnt == TWES_CNT_END);
    c_wp_block: cover property (st.fsm == TWES_WDAT && ev.wp && ev.scl_fall
        && st.cnt == TWES_CNT_ACK);
    c_prog_done: cover property ($fell(busy));

endmodule : twes_eeprom_slave

//--- twes_master_model.sv
`timescale 1ns/10ps
module twes_master_model (
    input wire logic clk_sys, // Pacing clock
    input wire logic sda_line, // Resolved data line
    output logic scl, // Serial clock to device
    output logic sda_pull // High pulls data low
);
    // ------------------------------------------------------------
    // Bus phases, paced off the system clock
    // ------------------------------------------------------------
    logic tgl = 1'b0;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : w
    // Clock parks low before bits
    task automatic idle_low();
        w(3);
        scl <= 1'b0;
    endtask : idle_low
    // data moves with clock low only
    task automatic bit_x(input logic rel, output logic smp);
        w(3);
        sda_pull <= !rel;
        w(3);
        scl <= 1'b1;
        w(3);
        smp = sda_line;
        // Odd high phase keeps a 125 ns mean period
        w(3 + int'(tgl));
        scl <= 1'b0;
        tgl = !tgl;
    endtask : bit_x
    task automatic start_c();
        w(3);
        sda_pull <= 1'b0;
        w(3);
        scl <= 1'b1;
        w(6);
        sda_pull <= 1'b1;
        w(6);
        scl <= 1'b0;
    endtask : start_c
    task automatic stop_c();
        w(3);
        sda_pull <= 1'b1;
        w(3);
        scl <= 1'b1;
        w(6);
        sda_pull <= 1'b0;
        w(6);
    endtask : stop_c
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask : wr_byte
    task automatic rd_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(!ack, s);
    endtask : rd_byte
endmodule : twes_master_model

//--- two_wire_eeprom_slave_tb_top.sv
`timescale 1ns/10ps
module two_wire_eeprom_slave_tb_top;
    import twes_pkg::*;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    localparam int unsigned PROG = 200;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic wp_in = 1'b0;
    logic scl, sda_pull, sda_out, sda_oe_n, busy, standby, sda_line;
    int err_total = 0;
    int checked = 0;
    assign sda_line = !(!sda_oe_n || sda_pull);
    always #5 clk_sys = ~clk_sys;
    twes_eeprom_slave #(.PROG_CYCLES(PROG)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .chip_select_strap_high(1'b1), .chip_select_strap_mid(1'b0),
        .chip_select_strap_low(1'b1), .wp_in(wp_in), .busy(busy), .standby(standby));
    twes_master_model u_m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        #1;
        checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : check
    task automatic wrap_up();
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    function automatic logic [7:0] dvb(input logic [2:0] s, input logic rw);
        return {TWES_DEV_TYPE, s, rw};
    endfunction : dvb
    function automatic logic [7:0] pexp(input int k);
        int i;
        i = (k + 2) % 64;
        if (i < 2) i += 64;
        return 8'(i + 16);
    endfunction : pexp
    task automatic set_loc(input logic [7:0] hi, input logic [7:0] lo);
        logic ak;
        u_m.start_c();
        u_m.wr_byte(dvb(3'h5, 1'b0), ak);
        check("dev ack", 1, ak);
        u_m.wr_byte(hi, ak);
        check("hi ack", 1, ak);
        u_m.wr_byte(lo, ak);
        check("lo ack", 1, ak);
    endtask : set_loc
    task automatic read_at(input logic [13:0] a, input logic more, output logic [7:0] d);
        logic ak;
        set_loc({2'b00, a[13:8]}, a[7:0]);
        u_m.start_c();
        u_m.wr_byte(dvb(3'h5, 1'b1), ak);
        check("read ack", 1, ak);
        u_m.rd_byte(more, d);
    endtask : read_at
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < PROG + 20) begin
            @(posedge clk_sys);
            n++;
        end
        check("busy end", 0, busy);
        check("standby", 1, standby);
    endtask : wait_idle
    task automatic byte_wr(input logic [13:0] a, input logic [7:0] d, input logic poll);
        logic ak;
        set_loc({2'b00, a[13:8]}, a[7:0]);
        u_m.wr_byte(d, ak);
        check("data ack", 1, ak);
        u_m.stop_c();
        check("busy", 1, busy);
        if (poll) begin
            u_m.start_c();
            u_m.wr_byte(dvb(3'h5, 1'b0), ak);
            check("poll busy", 0, ak);
            u_m.stop_c();
        end
        wait_idle();
    endtask : byte_wr
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_select();
        logic ak;
        u_m.idle_low();
        u_m.wr_byte(dvb(3'h5, 1'b0), ak);
        check("no start", 0, ak);
        u_m.stop_c();
        for (int s = 0; s < 8; s++) begin
            u_m.start_c();
            u_m.wr_byte(dvb(s[2:0], 1'b0), ak);
            check("select", 16'(s == 5), ak);
            u_m.stop_c();
        end
        u_m.start_c();
        u_m.wr_byte({~TWES_DEV_TYPE, 3'h5, 1'b0}, ak);
        check("type", 0, ak);
        u_m.stop_c();
        check("standby", 1, standby);
    endtask : sc_select
    task automatic sc_bytewr();
        logic ak;
        logic [7:0] d;
        byte_wr(14'h0105, 8'hA5, 1'b1);
        u_m.start_c();
        u_m.wr_byte(dvb(3'h5, 1'b0), ak);
        check("poll done", 1, ak);
        u_m.stop_c();
        read_at(14'h0105, 1'b0, d);
        u_m.stop_c();
        check("byte", 8'hA5, d);
        check("standby", 1, standby);
    endtask : sc_bytewr
    task automatic sc_wp();
        logic ak;
        logic [7:0] d;
        @(posedge clk_sys);
        wp_in <= 1'b1;
        set_loc(8'h01, 8'h05);
        u_m.wr_byte(8'h5A, ak);
        check("wp nack", 0, ak);
        u_m.stop_c();
        check("wp busy", 0, busy);
        @(posedge clk_sys);
        wp_in <= 1'b0;
        read_at(14'h0105, 1'b0, d);
        u_m.stop_c();
        check("wp keep", 8'hA5, d);
    endtask : sc_wp
    task automatic sc_wrap();
        logic [7:0] d;
        byte_wr(14'h3FFF, 8'h3C, 1'b0);
        byte_wr(14'h0000, 8'hC3, 1'b0);
        read_at(14'h3FFF, 1'b1, d);
        check("top", 8'h3C, d);
        u_m.rd_byte(1'b0, d);
        u_m.stop_c();
        check("wrap", 8'hC3, d);
    endtask : sc_wrap
    task automatic sc_page();
        logic ak;
        logic [7:0] d;
        set_loc(8'hCF, 8'hBE);
        for (int i = 0; i < 66; i++) begin
            u_m.wr_byte(8'(i + 16), ak);
            check("page ack", 1, ak);
        end
        u_m.stop_c();
        check("busy", 1, busy);
        wait_idle();
        read_at(14'h0F80, 1'b1, d);
        check("page", pexp(0), d);
        for (int k = 1; k < 63; k++) begin
            u_m.rd_byte(k < 62, d);
            check("page", pexp(k), d);
        end
        u_m.stop_c();
        u_m.start_c();
        u_m.wr_byte(dvb(3'h5, 1'b1), ak);
        u_m.rd_byte(1'b0, d);
        u_m.stop_c();
        check("current", pexp(63), d);
    endtask : sc_page
    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("oe idle", 1, sda_oe_n);
        check("sda out", 0, sda_out);
        check("standby", 1, standby);
        sc_select();
        sc_bytewr();
        sc_wp();
        sc_wrap();
        sc_page();
        wrap_up();
    end
    initial begin
        repeat (80000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
endmodule : two_wire_eeprom_slave_tb_top
